// ===== src/pfc_map.svh
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH
`define PFC_CLK_PERIOD_NS 8
`define PFC_CYC_CEIL(ns) (((ns) + `PFC_CLK_PERIOD_NS - 1) / `PFC_CLK_PERIOD_NS)
`define PFC_WE_PULSE_NS 40
`define PFC_WE_PULSE_CYC `PFC_CYC_CEIL(`PFC_WE_PULSE_NS)
`define PFC_READ_NS 70
`define PFC_SYNC_CYC 2
`define PFC_READ_CYC (`PFC_CYC_CEIL(`PFC_READ_NS) + `PFC_SYNC_CYC)
`define PFC_PROG_TMO_NS 20000
`define PFC_PROG_TMO_CYC `PFC_CYC_CEIL(`PFC_PROG_TMO_NS)
`define PFC_ERASE_TMO_CYC 12500000
`define PFC_SECTOR_BITS 12
`define PFC_UNLOCK_ADDR1 32'h0000_5555
`define PFC_UNLOCK_ADDR2 32'h0000_2aaa
`define PFC_UNLOCK_DATA1 8'haa
`define PFC_UNLOCK_DATA2 8'h55
`define PFC_SETUP_PROG 8'ha0
`define PFC_SETUP_ERASE 8'h80
`define PFC_CODE_SECTOR 8'h30
`define PFC_CODE_CHIP 8'h10
`define PFC_PROG_WRITES 4
`define PFC_ERASE_WRITES 6
`define PFC_POLL_BIT 7
`define PFC_ALT_BIT 6
`define PFC_CONFIRM_READS 2
`endif

// ===== src/pfc_pkg.sv
package pfc_pkg;
   typedef enum logic [1:0] {PFC_OP_READ, PFC_OP_PROGRAM, PFC_OP_SECTOR_ERASE,
      PFC_OP_CHIP_ERASE} pfc_op_type;
   typedef enum {BS_IDLE, BS_SETUP, BS_STROBE, BS_HOLD, BS_READ, BS_GAP} pfc_bus_state_type;
   typedef enum {MS_IDLE, MS_ISSUE, MS_WAIT, MS_POLL, MS_PWAIT, MS_DONE} pfc_seq_state_type;
endpackage : pfc_pkg

// ===== src/pfc_bus_cycle.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfc_map.svh"
module pfc_bus_cycle #(
   parameter int ADDR_W = 19
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic wr,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_i
);
   import pfc_pkg::*;
   localparam logic [7:0] WP_CYC = 8'(`PFC_WE_PULSE_CYC);
   localparam logic [7:0] RD_CYC = 8'(`PFC_READ_CYC);
   pfc_bus_state_type state_r;
   logic [7:0] cnt_r;
   logic [7:0] dq_meta_r;
   logic [7:0] dq_sync_r;

   // pin data comes from another device: two stages before use
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dq_meta_r <= 8'h00;
         dq_sync_r <= 8'h00;
      end
      else
      begin
         dq_meta_r <= flash_dq_i;
         dq_sync_r <= dq_meta_r;
      end
   end

   // one bus cycle: select, strobe, release, then a deselected gap
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= BS_IDLE;
         cnt_r <= 8'h00;
         done <= 1'b0;
         rdata <= 8'h00;
         flash_ce_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_addr <= '0;
         flash_dq_o <= 8'h00;
         flash_dq_oe <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state_r)
            BS_IDLE:
               if (start)
               begin
                  flash_addr <= addr;
                  flash_ce_n <= 1'b0;
                  if (wr)
                  begin
                     flash_dq_o <= wdata;
                     flash_dq_oe <= 1'b1;
                     state_r <= BS_SETUP;
                  end
                  else
                  begin
                     flash_oe_n <= 1'b0;
                     cnt_r <= RD_CYC - 8'h01;
                     state_r <= BS_READ;
                  end
               end
            BS_SETUP:
            begin
               // strobe falls last, so it is the edge that takes the address
               flash_we_n <= 1'b0;
               cnt_r <= WP_CYC - 8'h01;
               state_r <= BS_STROBE;
            end
            BS_STROBE:
               if (cnt_r == 8'h00)
               begin
                  flash_we_n <= 1'b1;
                  state_r <= BS_HOLD;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            BS_HOLD:
            begin
               flash_ce_n <= 1'b1;
               state_r <= BS_GAP;
            end
            BS_READ:
               if (cnt_r == 8'h00)
               begin
                  rdata <= dq_sync_r;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1; // each poll read is a separate read cycle
                  state_r <= BS_GAP;
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            BS_GAP:
            begin
               flash_dq_oe <= 1'b0;
               done <= 1'b1;
               state_r <= BS_IDLE;
            end
            default:
               state_r <= BS_IDLE;
         endcase
      end
   end

   a_we_needs_ce: assert property (@(posedge ref_clk) disable iff (!resetn)
      !flash_we_n |-> !flash_ce_n) else $error("write strobe low while deselected");
   a_we_pulse_width: assert property (@(posedge ref_clk) disable iff (!resetn)
      $fell(flash_we_n) |-> (!flash_we_n && flash_dq_oe) [*5]) else $error("write pulse short");
   a_data_held_rise: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe && $stable(flash_dq_o))
      else $error("data not held at strobe rise");
   a_addr_stable_we: assert property (@(posedge ref_clk) disable iff (!resetn)
      (!flash_ce_n && !$past(flash_ce_n)) |-> $stable(flash_addr))
      else $error("address moved within a cycle");
   a_no_drive_on_read: assert property (@(posedge ref_clk) disable iff (!resetn)
      !flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("drive contends with read");
endmodule : pfc_bus_cycle
`default_nettype wire

// ===== src/pfc_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "pfc_map.svh"
module pfc_seq #(
   parameter int ADDR_W = 19,
   parameter int ERASE_TMO_CYC = `PFC_ERASE_TMO_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire pfc_pkg::pfc_op_type cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_err,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [7:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [7:0] flash_dq_i
);
   import pfc_pkg::*;
   localparam logic [31:0] PROG_TMO = 32'(`PFC_PROG_TMO_CYC);
   localparam logic [31:0] ERASE_TMO = 32'(ERASE_TMO_CYC);
   localparam logic [2:0] PROG_N = 3'(`PFC_PROG_WRITES);
   localparam logic [2:0] ERASE_N = 3'(`PFC_ERASE_WRITES);
   localparam logic [1:0] CONFIRM = 2'(`PFC_CONFIRM_READS);

   pfc_seq_state_type state_r;
   pfc_op_type op_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0] data_r;
   logic [2:0] step_r;
   logic [2:0] nsteps;
   logic [31:0] tmo_r;
   logic [7:0] prev_r;
   logic have_prev_r;
   logic [1:0] stable_r;
   logic bus_start;
   logic bus_wr;
   logic bus_done;
   logic [7:0] bus_rdata;
   logic [ADDR_W-1:0] bus_addr;
   logic [7:0] bus_wdata;
   logic same_alt;
   logic expect_bit;

   // unlock table: address and data of each write of a sequence
   function automatic logic [ADDR_W+7:0] step_entry(input pfc_op_type op,
      input logic [2:0] step, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [ADDR_W-1:0] sector;
      logic [ADDR_W+7:0] e;
      sector = a & ~ADDR_W'((32'h1 << `PFC_SECTOR_BITS) - 32'h1);
      e = {ADDR_W'(`PFC_UNLOCK_ADDR1), `PFC_UNLOCK_DATA1};
      case (step)
         3'd0: e = {ADDR_W'(`PFC_UNLOCK_ADDR1), `PFC_UNLOCK_DATA1};
         3'd1: e = {ADDR_W'(`PFC_UNLOCK_ADDR2), `PFC_UNLOCK_DATA2};
         3'd2: e = {ADDR_W'(`PFC_UNLOCK_ADDR1),
            (op == PFC_OP_PROGRAM) ? `PFC_SETUP_PROG : `PFC_SETUP_ERASE};
         3'd3: e = (op == PFC_OP_PROGRAM) ? {a, d}
            : {ADDR_W'(`PFC_UNLOCK_ADDR1), `PFC_UNLOCK_DATA1};
         3'd4: e = {ADDR_W'(`PFC_UNLOCK_ADDR2), `PFC_UNLOCK_DATA2};
         default: e = (op == PFC_OP_SECTOR_ERASE) ? {sector, `PFC_CODE_SECTOR}
            : {ADDR_W'(`PFC_UNLOCK_ADDR1), `PFC_CODE_CHIP};
      endcase
      return e;
   endfunction : step_entry

   // sequence length per operation
   always_comb
   begin
      case (op_r)
         PFC_OP_PROGRAM: nsteps = PROG_N;
         PFC_OP_SECTOR_ERASE, PFC_OP_CHIP_ERASE: nsteps = ERASE_N;
         default: nsteps = 3'd0;
      endcase
   end

   // bus requests; a new command is only accepted when idle
   assign cmd_ready = (state_r == MS_IDLE);
   assign bus_start = (state_r == MS_ISSUE) || (state_r == MS_POLL);
   assign bus_wr = (state_r == MS_ISSUE) && (step_r < nsteps);
   assign {bus_addr, bus_wdata} = bus_wr ? step_entry(op_r, step_r, addr_r, data_r)
      : {addr_r, 8'h00};
   assign same_alt = bus_rdata[`PFC_ALT_BIT] == prev_r[`PFC_ALT_BIT];
   assign expect_bit = (op_r == PFC_OP_PROGRAM) ? data_r[`PFC_POLL_BIT] : 1'b1;

   // command capture and sequencing
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r <= MS_IDLE;
         op_r <= PFC_OP_READ;
         addr_r <= '0;
         data_r <= 8'h00;
         step_r <= 3'd0;
      end
      else
      begin
         case (state_r)
            MS_IDLE:
               if (cmd_valid)
               begin
                  op_r <= cmd_op;
                  addr_r <= cmd_addr;
                  data_r <= cmd_data;
                  step_r <= 3'd0;
                  state_r <= MS_ISSUE;
               end
            MS_ISSUE:
               state_r <= MS_WAIT;
            MS_WAIT:
               // a started sequence always runs to its end, so none is left half done
               if (bus_done)
               begin
                  if (op_r == PFC_OP_READ)
                     state_r <= MS_DONE;
                  else if (step_r == nsteps - 3'd1)
                     state_r <= MS_POLL;
                  else
                  begin
                     step_r <= step_r + 3'd1;
                     state_r <= MS_ISSUE;
                  end
               end
            MS_POLL:
               state_r <= MS_PWAIT;
            MS_PWAIT:
               if (bus_done)
               begin
                  if ((have_prev_r && same_alt && stable_r == CONFIRM - 2'd1) || tmo_r == 32'h0)
                     state_r <= MS_DONE;
                  else
                     state_r <= MS_POLL;
               end
            MS_DONE:
               state_r <= MS_IDLE;
            default:
               state_r <= MS_IDLE;
         endcase
      end
   end

   // status polling: alternating bit must hold still over the confirming reads
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tmo_r <= 32'h0;
         prev_r <= 8'h00;
         have_prev_r <= 1'b0;
         stable_r <= 2'd0;
      end
      else if (state_r == MS_WAIT && bus_done)
      begin
         tmo_r <= (op_r == PFC_OP_PROGRAM) ? PROG_TMO : ERASE_TMO;
         have_prev_r <= 1'b0;
         stable_r <= 2'd0;
      end
      else if (state_r == MS_POLL || state_r == MS_PWAIT)
      begin
         if (tmo_r != 32'h0)
            tmo_r <= tmo_r - 32'h1;
         if (state_r == MS_PWAIT && bus_done)
         begin
            prev_r <= bus_rdata;
            have_prev_r <= 1'b1;
            stable_r <= (have_prev_r && same_alt) ? stable_r + 2'd1 : 2'd0;
         end
      end
   end

   // answer: read data, or final status with error on timeout or wrong poll bit
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_err <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         if (state_r == MS_WAIT && bus_done && op_r == PFC_OP_READ)
         begin
            rsp_data <= bus_rdata;
            rsp_err <= 1'b0;
         end
         else if (state_r == MS_PWAIT && bus_done)
         begin
            rsp_data <= bus_rdata;
            rsp_err <= !(have_prev_r && same_alt) || bus_rdata[`PFC_POLL_BIT] != expect_bit;
         end
         if (state_r == MS_DONE)
            rsp_valid <= 1'b1;
      end
   end

   pfc_bus_cycle #(.ADDR_W(ADDR_W)) u_bus (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .start(bus_start),
      .wr(bus_wr),
      .addr(bus_addr),
      .wdata(bus_wdata),
      .done(bus_done),
      .rdata(bus_rdata),
      .flash_ce_n(flash_ce_n),
      .flash_we_n(flash_we_n),
      .flash_oe_n(flash_oe_n),
      .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_i(flash_dq_i)
   );

   // helper: writes issued in the current command
   logic [2:0] wr_cnt_r;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         wr_cnt_r <= 3'd0;
      else if (state_r == MS_IDLE)
         wr_cnt_r <= 3'd0;
      else if ($fell(flash_we_n))
         wr_cnt_r <= wr_cnt_r + 3'd1;
   end

   sequence s_last_write_done;
      state_r == MS_WAIT && bus_done && step_r == nsteps - 3'd1 && op_r != PFC_OP_READ;
   endsequence
   sequence s_first_poll;
      state_r == MS_POLL ##1 !flash_oe_n;
   endsequence

   a_prog_four_writes: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_last_write_done |-> op_r != PFC_OP_PROGRAM || wr_cnt_r == 3'd4)
      else $error("program not four writes");
   a_erase_six_writes: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_last_write_done |-> op_r == PFC_OP_PROGRAM || wr_cnt_r == 3'd6)
      else $error("erase not six writes");
   a_poll_after_write: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_last_write_done |=> s_first_poll) else $error("poll not started after last write");
   a_no_write_polling: assert property (@(posedge ref_clk) disable iff (!resetn)
      (state_r == MS_POLL || state_r == MS_PWAIT) |-> flash_we_n)
      else $error("write during operation");
   a_sector_aligned: assert property (@(posedge ref_clk) disable iff (!resetn)
      (bus_wr && op_r == PFC_OP_SECTOR_ERASE && step_r == 3'd5) |->
      bus_addr[`PFC_SECTOR_BITS-1:0] == '0 && bus_wdata == 8'h30)
      else $error("sector erase address or code wrong");
   a_chip_erase_code: assert property (@(posedge ref_clk) disable iff (!resetn)
      (bus_wr && op_r == PFC_OP_CHIP_ERASE && step_r == 3'd5) |->
      bus_addr == ADDR_W'(32'h5555) && bus_wdata == 8'h10)
      else $error("chip erase code wrong");
   a_rsp_one_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
      rsp_valid |=> !rsp_valid && cmd_ready) else $error("answer longer than one cycle");
   a_oe_we_exclusive: assert property (@(posedge ref_clk) disable iff (!resetn)
      !(!flash_oe_n && !flash_we_n)) else $error("output gate low during write");
endmodule : pfc_seq
`default_nettype wire

// ===== tb/pfc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_flash_model #(
   parameter int AW = 16,
   parameter int PROG_NS = 3000,
   parameter int ERASE_NS = 2000
) (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] dq_in,
   input wire logic slow,
   output logic [7:0] dq_out
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [AW-1:0] lat_a;
   logic [2:0] step_r;
   logic busy, erasing, tog;
   logic [7:0] pdata, held, rd_val;
   // writes need select and strobe low with the output gate high
   wire logic wr_act = !ce_n && !we_n && oe_n;
   wire logic rd_act = !ce_n && !oe_n;
   initial
   begin
      for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hff;
      step_r = 3'd0;
      busy = 1'b0;
      erasing = 1'b0;
      tog = 1'b0;
      pdata = 8'h00;
      held = 8'h5a;
   end
   // internal operation; slow stretches it past the controller's limit
   task automatic launch(input logic er);
      int ns;
      ns = er ? ERASE_NS : PROG_NS;
      if (slow) ns = ns * 8;
      erasing = er;
      busy = 1'b1;
      fork
         begin
            #(ns);
            busy = 1'b0;
         end
      join_none
   endtask : launch
   // unlock walk; any unexpected write drops back to plain reads
   task automatic accept(input logic [AW-1:0] a, input logic [7:0] d);
      logic u1, u2;
      u1 = (a == 16'h5555);
      u2 = (a == 16'h2aaa);
      case (step_r)
         3'd0: step_r = (u1 && d == 8'haa) ? 3'd1 : 3'd0;
         3'd1: step_r = (u2 && d == 8'h55) ? 3'd2 : 3'd0;
         3'd2: step_r = (u1 && d == 8'ha0) ? 3'd6 : (u1 && d == 8'h80) ? 3'd3 : 3'd0;
         3'd3: step_r = (u1 && d == 8'haa) ? 3'd4 : 3'd0;
         3'd4: step_r = (u2 && d == 8'h55) ? 3'd5 : 3'd0;
         3'd5:
         begin
            step_r = 3'd0;
            if (d == 8'h30)
            begin
               for (int i = 0; i < 4096; i++) mem[{a[AW-1:12], 12'h000} + i] = 8'hff;
               launch(1'b1);
            end
            else if (u1 && d == 8'h10)
            begin
               for (int i = 0; i < (1 << AW); i++) mem[i] = 8'hff;
               launch(1'b1);
            end
         end
         3'd6:
         begin
            step_r = 3'd0;
            mem[a] = mem[a] & d;
            pdata = d;
            launch(1'b0);
         end
         default: step_r = 3'd0;
      endcase
   endtask : accept
   // address on the later falling edge of the two strobes
   always @(posedge wr_act) lat_a = addr;
   // data on the earlier rising edge; ignored while busy
   always @(negedge wr_act) if (!busy) accept(lat_a, dq_in);
   // status bit flips once per read while busy
   always @(posedge rd_act) if (busy) tog = ~tog;
   // only status while busy, array byte otherwise
   always @*
   begin
      if (busy)
         rd_val = {erasing ? 1'b0 : ~pdata[7], tog, 6'h15};
      else
         rd_val = mem[addr];
      dq_out = rd_act ? rd_val : held;
   end
   // released bus shows no stale byte
   always @(negedge rd_act) held = ~rd_val;
endmodule : pfc_flash_model
`default_nettype wire

// ===== tb/pfc_seq_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_seq_tb_top;
   import pfc_pkg::*;
   localparam int AW = 16;
   logic ref_clk, resetn, cmd_valid, cmd_ready, rsp_valid, rsp_err, slow;
   logic ce_n, we_n, oe_n, dq_oe, er;
   pfc_op_type cmd_op;
   logic [AW-1:0] cmd_addr, f_addr;
   logic [AW-1:0] pa [0:5];
   logic [7:0] cmd_data, rsp_data, dq_o, dev_dq, rd;
   logic [7:0] pd [0:5];
   logic alive [0:5];
   int fails, n_compared, cyc, seed, r;
   // host drive wins while enabled, else whatever the device shows
   wire logic [7:0] dq_bus = dq_oe ? dq_o : dev_dq;
   pfc_seq #(.ADDR_W(AW), .ERASE_TMO_CYC(1000)) dut (.ref_clk(ref_clk), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
      .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
      .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(f_addr),
      .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_bus));
   pfc_flash_model #(.AW(AW)) flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(f_addr),
      .dq_in(dq_bus), .slow(slow), .dq_out(dev_dq));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic complete_run();
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run
   // hang guard, far above the longest expected run
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         fails++;
         complete_run();
      end
   end
   function automatic logic [7:0] exp_rd(input int i);
      return alive[i] ? pd[i] : 8'hff;
   endfunction : exp_rd
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // request held until taken, then wait for the one-cycle answer
   task automatic run_cmd(input pfc_op_type op, input logic [AW-1:0] a, input logic [7:0] d);
      int n;
      @(negedge ref_clk);
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_valid = 1'b1;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100)
      begin
         @(negedge ref_clk);
         n++;
      end
      // a request never taken is a hang in the command port
      if (cmd_ready !== 1'b1)
      begin
         fails++;
         $display("ERROR cmd_ready expected 1 seen %b", cmd_ready);
      end
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 30000)
      begin
         @(negedge ref_clk);
         n++;
      end
      // an answer that never comes counts against the run
      if (rsp_valid !== 1'b1)
      begin
         fails++;
         $display("ERROR rsp_valid expected 1 seen %b", rsp_valid);
      end
      rd = rsp_data;
      er = rsp_err;
   endtask : run_cmd
   initial
   begin
      seed = 32'h3f048f91;
      fails = 0;
      n_compared = 0;
      cyc = 0;
      cmd_valid = 1'b0;
      cmd_op = PFC_OP_READ;
      cmd_addr = '0;
      cmd_data = 8'h00;
      slow = 1'b0;
      resetn = 1'b0;
      repeat (10) @(negedge ref_clk);
      resetn = 1'b1;
      run_cmd(PFC_OP_READ, 16'h1234, 8'h00);
      check("blank read", 8'hff, rd);
      // one byte per sector; corner bytes with bit 7 clear first
      for (int i = 0; i < 6; i++)
      begin
         r = $random(seed);
         pa[i] = {i[3:0], r[11:0]};
         r = $random(seed);
         pd[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : r[7:0];
         alive[i] = 1'b1;
         run_cmd(PFC_OP_PROGRAM, pa[i], pd[i]);
         check("program status", pd[i], rd);
         check("program error", 8'h00, {7'h00, er});
         run_cmd(PFC_OP_READ, pa[i], 8'h00);
         check("program readback", exp_rd(i), rd);
      end
      run_cmd(PFC_OP_SECTOR_ERASE, pa[2], 8'h00);
      alive[2] = 1'b0;
      check("sector status", 8'hff, rd);
      check("sector error", 8'h00, {7'h00, er});
      // only the erased sector goes blank
      for (int i = 0; i < 6; i++)
      begin
         run_cmd(PFC_OP_READ, pa[i], 8'h00);
         check("sector readback", exp_rd(i), rd);
      end
      run_cmd(PFC_OP_CHIP_ERASE, pa[4], 8'h00);
      for (int i = 0; i < 6; i++) alive[i] = 1'b0;
      check("chip status", 8'hff, rd);
      check("chip error", 8'h00, {7'h00, er});
      run_cmd(PFC_OP_READ, pa[5], 8'h00);
      check("chip readback", exp_rd(5), rd);
      // device overruns the erase limit, then refuses a program
      slow = 1'b1;
      run_cmd(PFC_OP_SECTOR_ERASE, pa[1], 8'h00);
      check("erase timeout", 8'h01, {7'h00, er});
      run_cmd(PFC_OP_PROGRAM, pa[3], 8'h00);
      check("ignored program error", 8'h01, {7'h00, er});
      run_cmd(PFC_OP_READ, pa[3], 8'h00);
      check("ignored program readback", exp_rd(3), rd);
      complete_run();
   end
endmodule : pfc_seq_tb_top
`default_nettype wire
